// File: cdpa_assertions.sv
`timescale 1ns/1ps
// Port checks of alignment control, output decode and bus answers.
module cdpa_assertions
  import cdpa_pkg::*;
(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             sysref_in,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic [NCH-1:0]   clock_output_on,
  input wire logic [NCH-1:0]   clock_output_style,
  input wire logic [2*NCH-1:0] clock_output_amp,
  input wire logic             align_busy
);
  logic [NCH-1:0] amp_nz;    // Outputs showing any swing.
  logic [NCH-1:0] lvds_top;  // LVDS outputs showing the top swing.

  // Flags per output for the decode checks.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      amp_nz[i] = |clock_output_amp[2*i+:2];
      lvds_top[i] = !clock_output_style[i] && clock_output_amp[2*i+:2] == AMP_1000;
    end
  end

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  trig_edge_a: assert property ($rose(align_busy) |-> $past(sysref_in) && !$past(sysref_in, 2))
    else $error("alignment began without a sysref rise");
  busy_bound_a: assert property ($rose(align_busy) |-> ##[1:48] !align_busy)
    else $error("alignment ran too long");
  busy_min_a: assert property ($rose(align_busy) |=> align_busy)
    else $error("alignment ended at once");
  off_swing_a: assert property ((amp_nz & ~clock_output_on) == '0)
    else $error("powered-down output swings");
  lvds_swing_a: assert property (lvds_top == '0)
    else $error("LVDS output at top swing");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                              |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken before answer");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");

  cover property ($fell(align_busy));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (clock_output_style[0] && clock_output_amp[1:0] == AMP_1000);
endmodule

bind cdpa_top cdpa_assertions u_chk (.*);

// File: cdpa_divider.sv
`timescale 1ns/1ps
// One channel divider that can stretch its period to catch a shared phase target.
module cdpa_divider
  import cdpa_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [4:0] ratio,         // Divide ratio, 1 to 24.
  input  wire logic [7:0] delay,         // Clock phase delay in input periods.
  input  wire logic       align_start,   // One-cycle pulse at the trigger.
  input  wire logic       align_active,  // High while alignment runs.
  output logic            level,         // Divided clock level.
  output logic            matched        // Counter sits on the target phase.
);

  // Whole state of the divider.
  typedef struct packed {
    logic [4:0] cnt;  // Position inside the output period.
    logic [4:0] tgt;  // Position every aligned buffer agrees on.
    logic       lvl;  // Registered output level.
  } cdpa_div_t;

  cdpa_div_t div_reg;
  cdpa_div_t div_next;

  // Steps a position by one inside the period.
  function automatic logic [4:0] step(input logic [4:0] p, input logic [4:0] n);
    step = (p >= n - 5'h01) ? 5'h00 : p + 5'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Next state: the counter holds one extra input period while it trails the target.
  always_comb begin
    logic [4:0] dmod;
    dmod = 5'(delay % ratio);
    div_next = div_reg;
    // The target advances every cycle; a trigger loads it with the delayed phase.
    if (align_start) begin
      div_next.tgt = (dmod == 5'h00) ? 5'h00 : ratio - dmod;
    end else begin
      div_next.tgt = step(div_reg.tgt, ratio);
    end
    // Divide by one never holds, so that output keeps running unchanged.
    if (align_active && ratio != 5'h01 && div_reg.cnt != div_reg.tgt) begin
      div_next.cnt = div_reg.cnt;
    end else begin
      div_next.cnt = step(div_reg.cnt, ratio);
    end
    // High for the first half of the period; a steady high stands for divide by one.
    div_next.lvl = div_next.cnt < ((ratio + 5'h01) >> 1);
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign level   = div_reg.lvl;
  assign matched = (ratio == 5'h01) || (div_reg.cnt == div_reg.tgt);

endmodule

// File: cdpa_pkg.sv
// Shared constants for the divider phase-alignment and output-control block.
package cdpa_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Structure sizes.
  localparam int NCH      = 4;   // Clock channels, each with one divider.
  localparam int NOUT     = 8;   // Output config slots: 0..3 clock, 4..7 sysref-capable.
  localparam int OCFG_W   = 11;  // Width of one output config word.
  localparam int CLK_PIPE = 4;   // Clock path stages so sysref tap 4 lines up with it.
  localparam int SREF_TAPS = 8;  // Sysref phase delay steps.

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_CTRL     = 8'h00;  // Bit 0 is the alignment request.
  localparam logic [7:0] ADDR_STATUS   = 8'h04;  // Alignment state, read only.
  localparam logic [7:0] ADDR_CHAN0    = 8'h10;  // Four channel words, one per channel.
  localparam logic [7:0] ADDR_OUT0     = 8'h20;  // Eight output config words.

  // Channel word fields.
  localparam int CH_DIV_LO = 0;   // Divider code, 4 bits.
  localparam int CH_DLY_LO = 8;   // Clock phase delay setting, 8 bits.

  // Output config word fields.
  localparam int OC_PD      = 0;  // Power down.
  localparam int OC_EN      = 1;  // Enable; low forces static low.
  localparam int OC_STYLE   = 2;  // 0 selects LVDS, 1 selects LVPECL.
  localparam int OC_AMP_LO  = 3;  // Amplitude code, 2 bits.
  localparam int OC_SRC     = 5;  // Source select: 0 clock mode, 1 sysref mode.
  localparam int OC_SDLY_LO = 8;  // Sysref phase delay setting, 3 bits.

  // Reset values.
  localparam logic [3:0]        DIV_CODE_RST  = 4'h0;       // Divide by one.
  localparam logic [7:0]        CLK_DLY_RST   = 8'h00;      // Clock delay for closest alignment.
  localparam logic [OCFG_W-1:0] OCFG_CLK_RST  = 11'h002;    // Clock outputs on and enabled.
  localparam logic [OCFG_W-1:0] OCFG_SREF_RST = 11'h420;    // Sysref mode, disabled, delay 4.

  // Responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Amplitude level codes driven to the output stage.
  localparam logic [1:0] AMP_NONE = 2'h0;
  localparam logic [1:0] AMP_350  = 2'h1;
  localparam logic [1:0] AMP_750  = 2'h2;
  localparam logic [1:0] AMP_1000 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Alignment timing: the bound is counted in input clock periods.
  localparam int         ALIGN_MAX_PERIODS = 48;
  localparam logic [5:0] ALIGN_LAST        = 6'(ALIGN_MAX_PERIODS - 1);

  // Alignment state machine.
  typedef enum logic {ST_IDLE, ST_ALIGN} cdpa_state_t;

  // Maps a divider code to its ratio; codes above 8 fall back to divide by one.
  function automatic logic [4:0] ratio_of(input logic [3:0] code);
    case (code)
      4'h1:    ratio_of = 5'h02;
      4'h2:    ratio_of = 5'h03;
      4'h3:    ratio_of = 5'h04;
      4'h4:    ratio_of = 5'h06;
      4'h5:    ratio_of = 5'h08;
      4'h6:    ratio_of = 5'h0c;
      4'h7:    ratio_of = 5'h10;
      4'h8:    ratio_of = 5'h18;
      default: ratio_of = 5'h01;
    endcase
  endfunction

endpackage

// File: cdpa_sysref_gen.sv
`timescale 1ns/1ps
// Upstream generator model: one sysref pulse per request.
module cdpa_sysref_gen (
  input wire logic aclk,      // Shared input clock, kept running.
  input wire logic fire,      // Request for one pulse.
  output logic     sysref_in  // Sysref level toward the block.
);
  logic [3:0] cnt_reg = 4'h0;  // High cycles left in the pulse.

  // Rise comes just after an edge, ahead of the next sampling edge.
  always @(posedge aclk) begin
    if (fire) begin
      cnt_reg <= 4'h8;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  assign sysref_in = (cnt_reg != 4'h0);
endmodule

// File: cdpa_top.sv
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Clock delay 0, sysref delay 4 align best.
// - Sysref delay 3 or less leads the clock.
// - Delays are fixed cycle counts, frequency independent.
// - Stretch divided periods one input period until aligned.
// - One sysref rising edge starts the alignment.
// - Divide-by-one outputs never stretch during alignment.
// - Enabled sysref outputs keep passing sysref input.
// - Aligned divided edges coincide, equal delay everywhere.
// - Alignment ends within 48 input periods.
// - Request bit clears itself after alignment.
// - Writing the request again re-arms alignment.
// - Request low: no alignment, sysref passes through.
// - Request high: next sysref rise triggers alignment.
// - Power-down, enable, style and amplitude decode.
module cdpa_top
  import cdpa_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             sysref_in,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [NCH-1:0]        clock_output,
  output logic [NCH-1:0]        clock_output_on,
  output logic [NCH-1:0]        clock_output_style,
  output logic [2*NCH-1:0]      clock_output_amp,
  output logic [NCH-1:0]        sysref_output,
  output logic [NCH-1:0]        sysref_output_on,
  output logic [NCH-1:0]        sysref_output_style,
  output logic [2*NCH-1:0]      sysref_output_amp,
  output logic                  align_busy
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // State of the whole block outside the dividers in one register.
  typedef struct packed {
    logic                             awready;     // Write address may be taken.
    logic                             wready;      // Write data may be taken.
    logic                             aw_got;      // Write address held.
    logic                             w_got;       // Write data held.
    logic [7:0]                       aw_addr;     // Held write address.
    logic [31:0]                      w_data;      // Held write data.
    logic [3:0]                       w_strb;      // Held byte strobes.
    logic                             bvalid;      // Write response pending.
    logic [1:0]                       bresp;       // Write response code.
    logic                             arready;     // Read address may be taken.
    logic                             rvalid;      // Read data pending.
    logic [1:0]                       rresp;       // Read response code.
    logic [31:0]                      rdata;       // Read data.
    logic                             align_req;   // Alignment request bit.
    cdpa_state_t                      st;          // Alignment state.
    logic [5:0]                       align_cnt;   // Input periods since the trigger.
    logic                             align_start; // Pulse that loads divider targets.
    logic                             sref_q;      // Previous sysref sample.
    logic [SREF_TAPS-1:0]             sref_hist;   // Sysref delay line.
    logic [NCH-1:0][3:0]              div_code;    // Divider codes.
    logic [NCH-1:0][7:0]              clk_dly;     // Clock phase delay settings.
    logic [NOUT-1:0][OCFG_W-1:0]      ocfg;        // Output config words.
    logic [NCH-1:0][CLK_PIPE-1:0]     clk_hist;    // Clock path pipeline.
    logic [NCH-1:0]                   clk_o;       // Clock output levels.
    logic [NCH-1:0]                   clk_on;      // Clock output powered.
    logic [NCH-1:0]                   clk_sty;     // Clock output style.
    logic [NCH-1:0][1:0]              clk_amp;     // Clock output amplitude.
    logic [NCH-1:0]                   sr_o;        // Configurable output levels.
    logic [NCH-1:0]                   sr_on;       // Configurable output powered.
    logic [NCH-1:0]                   sr_sty;      // Configurable output style.
    logic [NCH-1:0][1:0]              sr_amp;      // Configurable output amplitude.
  } cdpa_state_reg_t;

  cdpa_state_reg_t s_reg;
  cdpa_state_reg_t s_next;

  logic [NCH-1:0] div_level;    // Divider output levels.
  logic [NCH-1:0] div_matched;  // Dividers on target.

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Merges written bytes into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // Amplitude level for a config word; off or disabled gives no swing.
  function automatic logic [1:0] amp_of(input logic [OCFG_W-1:0] c);
    logic [1:0] a;
    a = c[OC_AMP_LO +: 2];
    if (c[OC_PD] || !c[OC_EN]) begin
      amp_of = AMP_NONE;
    end else if (!c[OC_STYLE]) begin
      amp_of = a[0] ? AMP_750 : AMP_350;
    end else begin
      amp_of = (a == 2'h0) ? AMP_350 : (a == 2'h1) ? AMP_750 : AMP_1000;
    end
  endfunction

  // Output level: off or disabled holds static low.
  function automatic logic drive_of(input logic [OCFG_W-1:0] c, input logic d);
    drive_of = !c[OC_PD] && c[OC_EN] && d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // One divider per channel.
  for (genvar ch = 0; ch < NCH; ch++) begin : g_div
    cdpa_divider u_div (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .ratio        (ratio_of(s_reg.div_code[ch])),
      .delay        (s_reg.clk_dly[ch]),
      .align_start  (s_reg.align_start),
      .align_active (s_reg.st == ST_ALIGN),
      .level        (div_level[ch]),
      .matched      (div_matched[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Next state for the bus slave, the alignment control and the output stage.
  always_comb begin
    logic        rise;
    logic        wr_fire;
    logic        clr_req;
    logic [31:0] rd;
    logic [31:0] cur;
    logic        hit;
    logic [7:0]  ra;
    logic [7:0]  wa;
    logic [OCFG_W-1:0] oc;
    rise    = 1'b0;
    wr_fire = 1'b0;
    clr_req = 1'b0;
    rd      = 32'h0000_0000;
    cur     = 32'h0000_0000;
    hit     = 1'b0;
    ra      = s_reg.rdata[7:0];
    wa      = s_reg.aw_addr;
    oc      = '0;
    s_next  = s_reg;
    s_next.align_start = 1'b0;

    // Sysref is sampled on the clock edge and a low-to-high step is the trigger.
    s_next.sref_q = sysref_in;
    rise = sysref_in && !s_reg.sref_q;
    s_next.sref_hist = {s_reg.sref_hist[SREF_TAPS-2:0], sysref_in};

    // Alignment control.
    case (s_reg.st)
      ST_IDLE: begin
        // Without a request the edge only flows to the sysref outputs.
        if (s_reg.align_req && rise) begin
          s_next.st          = ST_ALIGN;
          s_next.align_cnt   = 6'h00;
          s_next.align_start = 1'b1;
        end
      end
      ST_ALIGN: begin
        s_next.align_cnt = s_reg.align_cnt + 6'h01;
        // Finish once every divider sits on target, or at the period bound.
        if ((s_reg.align_cnt != 6'h00 && (&div_matched)) || s_reg.align_cnt == ALIGN_LAST) begin
          s_next.st = ST_IDLE;
          clr_req   = 1'b1;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    if (clr_req) begin
      s_next.align_req = 1'b0;
    end

    // Write address and data are taken independently.
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Both halves held: perform the write and raise the response.
    wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    if (wr_fire) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      if (wa == ADDR_CTRL) begin
        // A written one re-arms and wins over a same-cycle self clear.
        if (s_reg.w_strb[0] && s_reg.w_data[0]) begin
          s_next.align_req = 1'b1;
        end else if (s_reg.w_strb[0]) begin
          s_next.align_req = 1'b0;
        end
      end else if (wa == ADDR_STATUS) begin
        s_next.bresp = RESP_OKAY;
      end else if (wa >= ADDR_CHAN0 && wa < ADDR_OUT0 && wa[1:0] == 2'h0) begin
        cur = merge({16'h0000, s_reg.clk_dly[wa[3:2]], 4'h0, s_reg.div_code[wa[3:2]]},
                    s_reg.w_data, s_reg.w_strb);
        s_next.div_code[wa[3:2]] = cur[CH_DIV_LO +: 4];
        s_next.clk_dly[wa[3:2]]  = cur[CH_DLY_LO +: 8];
      end else if (wa >= ADDR_OUT0 && wa < 8'h40 && wa[1:0] == 2'h0) begin
        cur = merge({21'h000000, s_reg.ocfg[wa[4:2]]}, s_reg.w_data, s_reg.w_strb);
        s_next.ocfg[wa[4:2]] = cur[OCFG_W-1:0];
      end else begin
        s_next.bresp = RESP_SLVERR;
      end
    end

    // Reads answer one cycle after the address is taken.
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      ra  = s_axi_araddr;
      hit = 1'b1;
      if (ra == ADDR_CTRL) begin
        rd = {31'h0, s_reg.align_req};
      end else if (ra == ADDR_STATUS) begin
        rd = {24'h0, 2'h0, s_reg.align_cnt};
        rd[31] = (s_reg.st == ST_ALIGN);
      end else if (ra >= ADDR_CHAN0 && ra < ADDR_OUT0 && ra[1:0] == 2'h0) begin
        rd = {16'h0000, s_reg.clk_dly[ra[3:2]], 4'h0, s_reg.div_code[ra[3:2]]};
      end else if (ra >= ADDR_OUT0 && ra < 8'h40 && ra[1:0] == 2'h0) begin
        rd = {21'h000000, s_reg.ocfg[ra[4:2]]};
      end else begin
        hit = 1'b0;
      end
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd;
      s_next.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Ready flags for the next cycle follow the held state.
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready  = !s_next.w_got && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;

    // Clock path: a fixed pipeline keeps the latency frequency independent.
    for (int ch = 0; ch < NCH; ch++) begin
      s_next.clk_hist[ch] = {s_reg.clk_hist[ch][CLK_PIPE-2:0], div_level[ch]};
      oc = s_reg.ocfg[ch];
      s_next.clk_o[ch]   = drive_of(oc, s_reg.clk_hist[ch][CLK_PIPE-1]);
      s_next.clk_on[ch]  = !oc[OC_PD];
      s_next.clk_sty[ch] = oc[OC_STYLE];
      s_next.clk_amp[ch] = amp_of(oc);
    end

    // Configurable outputs: source select picks the clock or the delayed sysref.
    for (int o = 0; o < NCH; o++) begin
      oc = s_reg.ocfg[NCH + o];
      if (oc[OC_SRC]) begin
        // Tap 4 matches the clock pipeline; lower taps lead the clock.
        s_next.sr_o[o] = drive_of(oc, s_reg.sref_hist[oc[OC_SDLY_LO +: 3]]);
      end else begin
        s_next.sr_o[o] = drive_of(oc, s_reg.clk_hist[o][CLK_PIPE-1]);
      end
      s_next.sr_on[o]  = !oc[OC_PD];
      s_next.sr_sty[o] = oc[OC_STYLE];
      s_next.sr_amp[o] = amp_of(oc);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg           <= '0;
      s_reg.awready   <= 1'b1;
      s_reg.wready    <= 1'b1;
      s_reg.arready   <= 1'b1;
      s_reg.st        <= ST_IDLE;
      s_reg.align_req <= 1'b0;
      for (int ch = 0; ch < NCH; ch++) begin
        s_reg.div_code[ch]   <= DIV_CODE_RST;
        s_reg.clk_dly[ch]    <= CLK_DLY_RST;
        s_reg.ocfg[ch]       <= OCFG_CLK_RST;
        s_reg.ocfg[NCH + ch] <= OCFG_SREF_RST;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Ports straight from the state register.
  assign s_axi_awready       = s_reg.awready;
  assign s_axi_wready        = s_reg.wready;
  assign s_axi_bvalid        = s_reg.bvalid;
  assign s_axi_bresp         = s_reg.bresp;
  assign s_axi_arready       = s_reg.arready;
  assign s_axi_rvalid        = s_reg.rvalid;
  assign s_axi_rdata         = s_reg.rdata;
  assign s_axi_rresp         = s_reg.rresp;
  assign clock_output        = s_reg.clk_o;
  assign clock_output_on     = s_reg.clk_on;
  assign clock_output_style  = s_reg.clk_sty;
  assign clock_output_amp    = s_reg.clk_amp;
  assign sysref_output       = s_reg.sr_o;
  assign sysref_output_on    = s_reg.sr_on;
  assign sysref_output_style = s_reg.sr_sty;
  assign sysref_output_amp   = s_reg.sr_amp;
  assign align_busy          = (s_reg.st == ST_ALIGN);

endmodule

// File: cdpa_top_tb.sv
`timescale 1ns/1ps
// Register-driven test of alignment, sysref pass-through and output decode.
module cdpa_top_tb
  import cdpa_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, sysref_in;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, align_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NCH-1:0] clock_output, clock_output_on, clock_output_style;
  logic [NCH-1:0] sysref_output, sysref_output_on, sysref_output_style;
  logic [2*NCH-1:0] clock_output_amp, sysref_output_amp;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  // Output word codes and the expected {on, style, amp} of each.
  logic [10:0] cfg [8] = '{11'h001, 11'h000, 11'h002, 11'h00a, 11'h006, 11'h00e, 11'h016, 11'h01e};
  logic [3:0] res [8] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hd, 4'he, 4'hf, 4'hf};

  cdpa_top dut (.*);
  cdpa_sysref_gen gen (.aclk, .fire, .sysref_in);

  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      $display("FAIL %0t %s", $time, m);
      mismatches++;
    end
  endtask

  // A wait that ran out ends the run.
  task automatic bound(input logic ok);
    chk(ok, "timeout");
    if (!ok) stop_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    // Let an edge pass so that bready never changes twice in one step.
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    bound(n < 40);
    chk(s_axi_bresp === r, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    // Let an edge pass so that rready never changes twice in one step.
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    bound(n < 40);
    chk(s_axi_rdata === d && s_axi_rresp === r, "read data");
  endtask

  // Sends one pulse and counts cycles until it shows on configurable output 4.
  task automatic lat(output int n);
    repeat (12) @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    for (n = 0; sysref_output[0] !== 1'b1 && n < 20; n++) begin
      chk(align_busy === 1'b0, "busy without request");
      @(posedge aclk);
    end
    bound(n < 20);
  endtask

  // Arms, triggers and times one alignment; returns divider phase after it.
  task automatic align(input int gap, output int ph);
    int n;
    int t0;
    logic p;
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    repeat (gap) @(posedge aclk);
    fire <= 1'b1;
    t0 = cyc;
    @(posedge aclk);
    fire <= 1'b0;
    for (n = 0; align_busy !== 1'b1 && n < 8; n++) @(posedge aclk);
    bound(n < 8);
    for (n = 0; align_busy === 1'b1 && n < 60; n++) begin
      chk(clock_output[0] === 1'b1, "divide by one disturbed");
      @(posedge aclk);
    end
    chk(n >= 2 && n <= 48, "alignment length");
    // Rises launched before the alignment must drain from the output pipeline first.
    repeat (CLK_PIPE + 1) @(posedge aclk);
    p = clock_output[1];
    for (n = 0; !(p === 1'b0 && clock_output[1] === 1'b1) && n < 30; n++) begin
      p = clock_output[1];
      @(posedge aclk);
    end
    bound(n < 30);
    ph = (cyc - t0) % 4;
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
  endtask

  // Main sequence.
  initial begin
    int a;
    int b;
    int n;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd(ADDR_OUT0, 32'h002, RESP_OKAY);
    rd(ADDR_OUT0 + 8'h10, 32'h420, RESP_OKAY);
    rd(8'h80, 32'h0, RESP_SLVERR);
    wr(8'h80, 32'h1, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_OUT0, {21'h0, cfg[i]}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({clock_output_on[0], clock_output_style[0], clock_output_amp[1:0]} === res[i], "decode");
    end
    wr(ADDR_OUT0, 32'h002, RESP_OKAY);
    wr(ADDR_OUT0 + 8'h10, 32'h002, RESP_OKAY);
    repeat (10) @(posedge aclk);
    chk(sysref_output[0] === 1'b1 && sysref_output_amp[1:0] === AMP_350, "clock mode");
    chk(sysref_output_on[0] === 1'b1 && sysref_output_style[0] === 1'b0, "mode pins");
    wr(ADDR_OUT0 + 8'h10, 32'h422, RESP_OKAY);
    lat(a);
    wr(ADDR_OUT0 + 8'h10, 32'h322, RESP_OKAY);
    lat(b);
    chk(b + 1 == a, "tap order");
    wr(ADDR_OUT0 + 8'h10, 32'h422, RESP_OKAY);
    lat(n);
    chk(n == a && sysref_output_amp[1:0] === AMP_350, "tap repeat");
    wr(ADDR_CHAN0 + 8'h04, 32'h3, RESP_OKAY);
    align(1250, a);
    align(1251, b);
    chk(a == b, "phase after alignment");
    stop_test();
  end
endmodule
